/* hw/bsp_dev_end.sv */
// SRAM end of the burst pin interface: two word arrays, byte lane writes,
// a read pipeline with two latencies, echo clocks and the valid flag.
// Assumes the host makes both input clocks slow against clock, so that
// every input clock edge is seen after the two-stage synchroniser.
//
// Functional notes
// - Active-low lane selects sampled on both clock edges
// - Narrow word: select 0 bits 8:0, 1 bits 17:9
// - Wide word: four selects, nine bits each
// - Deasserted lane keeps stored byte unchanged
// - Lane select sampled with its data word
// - Address taken on positive edge, shared bus
// - Two internal arrays, one per burst word
// - Strobe low: direction high reads, low writes
// - Valid flag aligned with echo clocks
// - Accesses start on positive clock rising edge
// - Negative edge takes write word, launches read word
// - Echo clocks toggle continuously, follow positive clock
// - Loop disable pin is active low
// - Loop off: one-cycle mode, clock at most 167 MHz
// - Strobe low starts cycle, burst of two words
// - Read latency 2.5 cycles, or 1 with loop off
// - Data outputs released when no read word
`timescale 1ns/10ps
module bsp_dev_end
#(
	parameter int DW = bsp_pkg::DATA_W_DEF,
	parameter int AW = bsp_pkg::ADDR_W_DEF
)
(
	// Clock, reset and clock enable
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic ce,
	// Pins towards the memory controller
	bsp_link_if.dev   lnk,
	// Status for local logic
	output logic      pll_on_mode_r,
	output logic      read_busy_r
);
	localparam int NL = DW / bsp_pkg::LANE_W;  // Lanes per word
	localparam int DEPTH = 2 ** AW;            // Words per array
	localparam int PD = bsp_pkg::RD_PIPE_DEPTH;
	localparam int SW = 4 + AW + NL + DW + 1;  // Synchronised bundle

	// Synchronised pins
	logic [SW-1:0] pins_raw;                   // Bundle as seen on pins
	logic [SW-1:0] pins_s;                     // Bundle after two flops
	logic          k_s;                        // Positive clock level
	logic          k_n_s;                      // Negative clock level
	logic          ld_n_s;                     // Load strobe
	logic          rd_s;                       // Direction
	logic [AW-1:0] addr_s;                     // Address
	logic [NL-1:0] lane_n_s;                   // Lane selects
	logic [DW-1:0] dq_s;                       // Data bus
	logic          pll_n_s;                    // Loop disable pin

	// Edge detection on the synchronised input clocks
	logic          k_d_r;                      // Previous positive level
	logic          k_n_d_r;                    // Previous negative level
	logic          k_rise;                     // Positive clock rose
	logic          kn_rise;                    // Negative clock rose
	logic          any_edge;                   // Either clock rose

	// Storage: one array per burst word
	logic [DW-1:0] mem0 [0:DEPTH-1];           // First word of burst
	logic [DW-1:0] mem1 [0:DEPTH-1];           // Second word of burst

	// Write pipeline
	logic          wr_arm_r;                   // Load seen, word 0 next
	logic [AW-1:0] wr_addr_r;                  // Address of armed write
	logic          wr_second_r;                // Word 1 due on next neg
	logic [AW-1:0] wr2_addr_r;                 // Address for word 1

	// Read pipeline, one slot per input clock edge
	logic [PD-1:0] rd_v_r;                     // Slot holds a read
	logic [AW-1:0] rd_a_r [0:PD-1];            // Address of each slot
	logic [2:0]    lat;                        // Edges to first word
	logic          word0_due;                  // First word launches now
	logic          word1_due;                  // Second word launches now

	// Output registers
	logic [DW-1:0] dq_out_r;                   // Data driven on the bus
	logic          dq_oe_r;                    // Bus drive enable
	logic          echo_r;                     // Echo of positive clock
	logic          echo_n_r;                   // Echo of negative clock
	logic          output_valid_flag_r;                     // Read word valid

	assign pins_raw = {lnk.k, lnk.k_n, lnk.cycle_load_strobe_n,
		lnk.access_dir_read, lnk.addr, lnk.byte_lane_write_select_n,
		lnk.dq, lnk.pll_disable_n};

	// All pins pass the same two flops, so their mutual alignment holds
	bsp_sync2 #(.W(SW)) u_pin_sync
	(
		.clock (clock),
		.rst   (rst),
		.ce    (ce),
		.d     (pins_raw),
		.q     (pins_s)
	);

	assign {k_s, k_n_s, ld_n_s, rd_s, addr_s, lane_n_s, dq_s, pll_n_s} =
		pins_s;

	// Rising edge detect on the second synchroniser stage
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			k_d_r   <= bsp_pkg::RST_OUT_LOW;
			k_n_d_r <= bsp_pkg::RST_OUT_LOW;
		end
		else if (ce)
		begin
			k_d_r   <= k_s;
			k_n_d_r <= k_n_s;
		end
	end

	assign k_rise   = k_s & ~k_d_r;
	assign kn_rise  = k_n_s & ~k_n_d_r;
	assign any_edge = k_rise | kn_rise;

	// Loop mode follows the pin; low means loop off, one-cycle mode
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			pll_on_mode_r <= bsp_pkg::RST_PLL_DISABLE_N;
		else if (ce)
			pll_on_mode_r <= pll_n_s;
	end

	// Latency in edges; the host keeps the clock slow in one-cycle mode
	assign lat = pll_on_mode_r ? bsp_pkg::LAT_EDGES_PLL_ON
		: bsp_pkg::LAT_EDGES_PLL_OFF;
	assign word0_due = kn_rise | k_rise ? rd_v_r[lat - 3'h1] : 1'b0;
	assign word1_due = any_edge ? rd_v_r[lat] : 1'b0;

	// Write control: load on positive edge, word 0 on the next positive
	// edge, word 1 on the negative edge after that
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wr_arm_r    <= 1'b0;
			wr_addr_r   <= '0;
			wr_second_r <= 1'b0;
			wr2_addr_r  <= '0;
		end
		else if (ce)
		begin
			if (k_rise)
			begin
				// A new load may share this edge with word 0 of the last one
				wr_arm_r  <= ~ld_n_s & ~rd_s;
				wr_addr_r <= addr_s;
				wr_second_r <= wr_arm_r;
				wr2_addr_r  <= wr_addr_r;
			end
			else if (kn_rise)
				wr_second_r <= 1'b0;
		end
	end

	// Array writes, lane by lane; memories carry no reset
	always_ff @(posedge clock)
	begin
		if (ce)
		begin
			for (int l = 0; l < NL; l++)
			begin
				// Lane l covers bits l*9 .. l*9+8 in either width
				if (k_rise && wr_arm_r && !lane_n_s[l])
					mem0[wr_addr_r][l*bsp_pkg::LANE_W +: bsp_pkg::LANE_W] <=
						dq_s[l*bsp_pkg::LANE_W +: bsp_pkg::LANE_W];
				// Unselected lanes are simply not written
				if (kn_rise && wr_second_r && !lane_n_s[l])
					mem1[wr2_addr_r][l*bsp_pkg::LANE_W +: bsp_pkg::LANE_W] <=
						dq_s[l*bsp_pkg::LANE_W +: bsp_pkg::LANE_W];
			end
		end
	end

	// Read pipeline shifts on every input clock edge; slot 0 takes a new read
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rd_v_r <= '0;
			for (int i = 0; i < PD; i++)
				rd_a_r[i] <= '0;
		end
		else if (ce && any_edge)
		begin
			rd_v_r <= {rd_v_r[PD-2:0], k_rise & ~ld_n_s & rd_s};
			rd_a_r[0] <= addr_s;
			for (int i = 1; i < PD; i++)
				rd_a_r[i] <= rd_a_r[i-1];
		end
	end

	// Data launch; every read runs to completion once loaded
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			dq_out_r <= '0;
			dq_oe_r  <= bsp_pkg::RST_OUT_LOW;
			output_valid_flag_r   <= bsp_pkg::RST_OUT_LOW;
		end
		else if (ce && any_edge)
		begin
			if (word0_due)
			begin
				dq_out_r <= mem0[rd_a_r[lat - 3'h1]];
				dq_oe_r  <= 1'b1;
				output_valid_flag_r   <= 1'b1;
			end
			else if (word1_due)
			begin
				dq_out_r <= mem1[rd_a_r[lat]];
				dq_oe_r  <= 1'b1;
				output_valid_flag_r   <= 1'b1;
			end
			else
			begin
				// Release the bus so another bank can follow without a gap
				dq_oe_r <= 1'b0;
				output_valid_flag_r  <= 1'b0;
			end
		end
	end

	// Echo clocks follow the inputs every cycle, access or not; taken from
	// the same stage as the edge detect so data and echo move together
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			echo_r   <= bsp_pkg::RST_OUT_LOW;
			echo_n_r <= bsp_pkg::RST_OUT_LOW;
		end
		else if (ce)
		begin
			echo_r   <= k_s;
			echo_n_r <= k_n_s;
		end
	end

	// Busy while any read sits in the pipeline or on the bus
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			read_busy_r <= 1'b0;
		else if (ce)
			read_busy_r <= (|rd_v_r) | dq_oe_r;
	end

	assign lnk.dq_dev            = dq_out_r;
	assign lnk.dq_dev_oe         = dq_oe_r;
	assign lnk.echo_clock_out    = echo_r;
	assign lnk.echo_clock_out_n  = echo_n_r;
	assign lnk.output_valid_flag = output_valid_flag_r;
endmodule

/* common/bsp_pkg.sv */
// Shared constants of the burst SRAM pin interface: lane layout, burst
// length, read latencies in half clock periods and link clock figures.
// Assumes both ends and the link interface are compiled after this file.
package bsp_pkg;

	// Data bits governed by one byte lane write select
	localparam int LANE_W = 9;
	// Words moved by every transaction
	localparam int BURST_LEN = 2;
	// Default organisation: 18-bit words, 1 M words per array
	localparam int DATA_W_DEF = 18;
	localparam int ADDR_W_DEF = 20;

	// Read latency counted in input clock edges (positive and negative)
	localparam logic [2:0] LAT_EDGES_PLL_ON = 3'h5;
	localparam logic [2:0] LAT_EDGES_PLL_OFF = 3'h2;
	// Read pipeline holds one slot per edge up to the second word
	localparam int RD_PIPE_DEPTH = 6;

	// Flip-flops in front of any logic that reads a pin
	localparam int SYNC_STAGES = 2;

	// System clock and the input clock the host derives from it
	localparam int CLOCK_MHZ = 100;
	localparam int K_HALF_CYCLES = 1;
	localparam int K_MHZ = CLOCK_MHZ / (2 * K_HALF_CYCLES);
	// Highest input clock allowed with the loop switched off
	localparam int PLL_OFF_MAX_MHZ = 167;

	// Values after reset
	localparam logic RST_PLL_DISABLE_N = 1'b1;
	localparam logic RST_STROBE_N = 1'b1;
	localparam logic RST_OUT_LOW = 1'b0;

endpackage

/* common/bsp_link_if.sv */
// Pin bundle between the memory controller end and the SRAM end.
// The shared data bus is resolved here from the two output enables.
`timescale 1ns/10ps
interface bsp_link_if
#(
	parameter int DW = bsp_pkg::DATA_W_DEF,
	parameter int AW = bsp_pkg::ADDR_W_DEF
);
	localparam int NL = DW / bsp_pkg::LANE_W;

	// Host driven pins
	logic            k;                        // Positive input clock
	logic            k_n;                      // Negative input clock
	logic            cycle_load_strobe_n;      // Low starts a bus cycle
	logic            access_dir_read;          // High read, low write
	logic [AW-1:0]   addr;                     // Shared address bus
	logic [NL-1:0]   byte_lane_write_select_n; // Per lane, active low
	logic            pll_disable_n;            // Low switches loop off
	logic [DW-1:0]   dq_host;                  // Host data out
	logic            dq_host_oe;               // Host drives data bus
	// Device driven pins
	logic [DW-1:0]   dq_dev;                   // Device data out
	logic            dq_dev_oe;                // Device drives data bus
	logic            echo_clock_out;           // Echo of positive clock
	logic            echo_clock_out_n;         // Echo of negative clock
	logic            output_valid_flag;        // Read word valid
	// Resolved data bus; an undriven bus reads as zero here
	logic [DW-1:0]   dq;

	assign dq = dq_host_oe ? dq_host : (dq_dev_oe ? dq_dev : '0);

	modport dev
	(
		input  k,
		input  k_n,
		input  cycle_load_strobe_n,
		input  access_dir_read,
		input  addr,
		input  byte_lane_write_select_n,
		input  pll_disable_n,
		input  dq,
		output dq_dev,
		output dq_dev_oe,
		output echo_clock_out,
		output echo_clock_out_n,
		output output_valid_flag
	);

	modport host
	(
		output k,
		output k_n,
		output cycle_load_strobe_n,
		output access_dir_read,
		output addr,
		output byte_lane_write_select_n,
		output pll_disable_n,
		output dq_host,
		output dq_host_oe,
		input  dq,
		input  echo_clock_out,
		input  echo_clock_out_n,
		input  output_valid_flag
	);
endinterface

/* hw/bsp_sync2.sv */
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes the bundle bits are independent levels sampled on clock.
`timescale 1ns/10ps
module bsp_sync2
#(
	parameter int W = 1
)
(
	// Clock and control
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         ce,
	// Pin side and synchronised side
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r; // First stage, read only by the second

	// Both stages freeze with the clock enable
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else if (ce)
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

/* hw/bsp_host_end.sv */
// Memory controller end: makes both input clocks from clock by division,
// issues one command per input clock period and collects read words.
// Assumes the user leaves turnaround gaps between reads and writes.
`timescale 1ns/10ps
module bsp_host_end
#(
	parameter int DW = bsp_pkg::DATA_W_DEF,
	parameter int AW = bsp_pkg::ADDR_W_DEF
)
(
	// Clock, reset and clock enable
	input  wire logic          clock,
	input  wire logic          rst,
	input  wire logic          ce,
	// Pins towards the SRAM
	bsp_link_if.host           lnk,
	// Command port
	input  wire logic          cmd_valid,
	output logic               cmd_ready_r,
	input  wire logic          cmd_write,
	input  wire logic [AW-1:0] cmd_addr,
	input  wire logic [DW-1:0] cmd_wdata0,
	input  wire logic [DW-1:0] cmd_wdata1,
	input  wire logic [DW/9-1:0] cmd_lane0,
	input  wire logic [DW/9-1:0] cmd_lane1,
	input  wire logic          pll_off,
	// Read return
	output logic [DW-1:0]      rd_data_r,
	output logic               rd_valid_r
);
	localparam int NL = DW / bsp_pkg::LANE_W;

	logic          k_r;                        // Positive input clock
	logic          k_n_r;                      // Negative input clock
	logic          ld_n_r;                     // Load strobe
	logic          rd_r;                       // Direction
	logic [AW-1:0] addr_r;                     // Address
	logic [NL-1:0] lane_n_r;                   // Lane selects on pins
	logic [DW-1:0] dq_r;                       // Write data on pins
	logic          dq_oe_r;                    // Host drives the bus
	logic          pll_n_r;                    // Loop disable pin
	logic          take;                       // Command accepted
	logic          w_pend_r;                   // Write words still due
	logic [DW-1:0] w0_r;                       // Pending word 0
	logic [DW-1:0] w1_r;                       // Pending word 1
	logic [NL-1:0] l0_r;                       // Pending lanes, word 0
	logic [NL-1:0] l1_r;                       // Pending lanes, word 1
	logic          w1_due_r;                   // Word 1 on next neg edge
	logic [DW-1:0] w1_hold_r;                  // Word 1 of launched write
	logic [NL-1:0] l1_hold_r;                  // Its lane enables
	logic [DW+2:0] ret_s;                      // Synchronised returns
	logic          echo_s;                     // Echo level
	logic          echo_n_s;                   // Negative echo level
	logic          output_valid_flag_s;                     // Valid level
	logic [DW-1:0] dq_s;                       // Bus data
	logic          echo_d_r;                   // Previous echo levels
	logic          echo_n_d_r;

	// Commands go out only on the cycle whose edge raises k
	assign take = ce & cmd_valid & cmd_ready_r;

	// Divider: k flips each enabled cycle, so 50 MHz from 100 MHz, which
	// also keeps one-cycle mode under its clock ceiling
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			k_r         <= 1'b0;
			k_n_r       <= 1'b1;
			cmd_ready_r <= 1'b0;
			pll_n_r     <= bsp_pkg::RST_PLL_DISABLE_N;
		end
		else if (ce)
		begin
			k_r         <= ~k_r;
			// Own flop so the pin never passes through an inverter
			k_n_r       <= k_r;
			cmd_ready_r <= k_r;                // High in the cycle before rise
			pll_n_r     <= ~pll_off;
		end
	end

	// Command and write data launch
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ld_n_r   <= bsp_pkg::RST_STROBE_N;
			rd_r     <= 1'b0;
			addr_r   <= '0;
			lane_n_r <= '1;
			dq_r     <= '0;
			dq_oe_r  <= 1'b0;
			w_pend_r <= 1'b0;
			w0_r     <= '0;
			w1_r     <= '0;
			l0_r     <= '0;
			l1_r     <= '0;
			w1_due_r <= 1'b0;
		end
		else if (ce)
		begin
			if (!k_r)
			begin
				// Positive edge: load a command, send word 0 of the last write
				ld_n_r   <= ~take;
				rd_r     <= take & ~cmd_write;
				addr_r   <= cmd_addr;
				w_pend_r <= take & cmd_write;
				w0_r     <= cmd_wdata0;
				w1_r     <= cmd_wdata1;
				l0_r     <= cmd_lane0;
				l1_r     <= cmd_lane1;
				dq_r     <= w0_r;
				lane_n_r <= w_pend_r ? ~l0_r : '1;
				dq_oe_r  <= w_pend_r;
				w1_due_r <= w_pend_r;
				// Second word of the old write moves with the pending data
				if (w_pend_r)
					w1_r <= take & cmd_write ? cmd_wdata1 : w1_r;
			end
			else
			begin
				// Negative edge: word 1 with its own lane selects
				ld_n_r   <= bsp_pkg::RST_STROBE_N;
				dq_r     <= w1_due_r ? w1_hold_r : dq_r;
				lane_n_r <= w1_due_r ? ~l1_hold_r : '1;
				dq_oe_r  <= w1_due_r;
				w1_due_r <= 1'b0;
			end
		end
	end

	// Word 1 of the write launched at the last positive edge
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			w1_hold_r <= '0;
			l1_hold_r <= '0;
		end
		else if (ce && !k_r)
		begin
			w1_hold_r <= w1_r;
			l1_hold_r <= l1_r;
		end
	end

	// Returns from the SRAM are pins: two flops first
	bsp_sync2 #(.W(DW + 3)) u_ret_sync
	(
		.clock (clock),
		.rst   (rst),
		.ce    (ce),
		.d     ({lnk.echo_clock_out, lnk.echo_clock_out_n,
			lnk.output_valid_flag, lnk.dq}),
		.q     (ret_s)
	);

	assign {echo_s, echo_n_s, output_valid_flag_s, dq_s} = ret_s;

	// Take a word on each echo edge while the valid flag stands
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			echo_d_r   <= 1'b0;
			echo_n_d_r <= 1'b0;
			rd_data_r  <= '0;
			rd_valid_r <= 1'b0;
		end
		else if (ce)
		begin
			echo_d_r   <= echo_s;
			echo_n_d_r <= echo_n_s;
			rd_valid_r <= 1'b0;
			if (((echo_s & ~echo_d_r) | (echo_n_s & ~echo_n_d_r)) && output_valid_flag_s)
			begin
				rd_data_r  <= dq_s;
				rd_valid_r <= 1'b1;
			end
		end
	end

	assign lnk.k                        = k_r;
	assign lnk.k_n                      = k_n_r;
	assign lnk.cycle_load_strobe_n      = ld_n_r;
	assign lnk.access_dir_read          = rd_r;
	assign lnk.addr                     = addr_r;
	assign lnk.byte_lane_write_select_n = lane_n_r;
	assign lnk.dq_host                  = dq_r;
	assign lnk.dq_host_oe               = dq_oe_r;
	assign lnk.pll_disable_n            = pll_n_r;
endmodule

/* verification/bsp_link_properties.sv */
// Checker for the pin link joining the controller end and the SRAM end.
// Assumes it is fed the link interface signals, one clock domain.
`timescale 1ns/10ps
module bsp_link_properties
#(
	parameter int AW = 20
)
(
	// Clock and reset
	input wire logic          clock,
	input wire logic          rst,
	// Host driven pins
	input wire logic          k,
	input wire logic          k_n,
	input wire logic          cycle_load_strobe_n,
	input wire logic          access_dir_read,
	input wire logic [AW-1:0] addr,
	input wire logic          pll_disable_n,
	input wire logic          dq_host_oe,
	// Device driven pins
	input wire logic          dq_dev_oe,
	input wire logic          echo_clock_out,
	input wire logic          echo_clock_out_n,
	input wire logic          output_valid_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	logic [3:0] up_cnt_r; // Cycles since reset, stops at 8

	// Echoes lag the pins through the synchroniser, so wait them out
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			up_cnt_r <= 4'h0;
		else if (up_cnt_r != 4'h8)
			up_cnt_r <= up_cnt_r + 4'h1;
	end

	echo_toggle_a: assert property (up_cnt_r == 4'h8 |=>
		!$stable(echo_clock_out)) else $error("echo clock stalled");
	echo_pair_a: assert property (up_cnt_r == 4'h8 |->
		echo_clock_out_n == ~echo_clock_out) else $error("echo pair");
	valid_oe_a: assert property (output_valid_flag |->
		dq_dev_oe) else $error("valid flag without drive");
	valid_edge_a: assert property ($rose(output_valid_flag) |->
		(pll_disable_n ? $rose(echo_clock_out_n) : $rose(echo_clock_out)))
		else $error("valid flag off echo");
	valid_burst_a: assert property ($rose(output_valid_flag) |=>
		output_valid_flag) else $error("single word burst");
	bus_release_a: assert property ($fell(output_valid_flag) |->
		##[0:1] !dq_dev_oe) else $error("bus not released");
	load_edge_a: assert property ($fell(cycle_load_strobe_n) |->
		$rose(k)) else $error("load off clock edge");
	addr_hold_a: assert property (!cycle_load_strobe_n && $rose(k) |=>
		$stable(addr)) else $error("address moved");
	wdata_edge_a: assert property ($rose(dq_host_oe) |-> $rose(k)
		##1 ($rose(k_n) && dq_host_oe)) else $error("write word edge");
	lat_on_a: assert property ($rose(k) && !cycle_load_strobe_n
		&& access_dir_read && pll_disable_n |-> ##[6:10]
		$rose(output_valid_flag)) else $error("loop on latency");
	lat_off_a: assert property ($rose(k) && !cycle_load_strobe_n
		&& access_dir_read && !pll_disable_n |-> ##[2:6]
		$rose(output_valid_flag)) else $error("loop off latency");

	// Main scenarios
	cover property ($rose(k) && !cycle_load_strobe_n && !access_dir_read);
	cover property ($rose(output_valid_flag) && pll_disable_n);
	cover property ($rose(output_valid_flag) && !pll_disable_n);
endmodule

/* verification/burst_sram_pin_interface_tb_top.sv */
// Bench top: both ends joined by the link, command port driven here.
// Assumes the default 18-bit word and 20-bit address organisation.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
	begin \
		checks++; \
		if ((gt) !== (ex)) \
		begin \
			n_fail++; \
			$display("Error %s expected %h seen %h", nm, ex, gt); \
		end \
	end
module burst_sram_pin_interface_tb_top;
	localparam int DW = bsp_pkg::DATA_W_DEF;
	localparam int AW = bsp_pkg::ADDR_W_DEF;
	localparam int NL = DW / bsp_pkg::LANE_W;
	localparam int LW = bsp_pkg::LANE_W;

	// One write: address, both words and their lane enables
	typedef struct packed
	{
		logic [AW-1:0] a;
		logic [DW-1:0] d0;
		logic [DW-1:0] d1;
		logic [NL-1:0] l0;
		logic [NL-1:0] l1;
	} bsp_row_s;

	// Full writes first so no array word stays unknown
	bsp_row_s rows [6] = '{
		'{20'h00010, 18'h3a5a5, 18'h05a5a, 2'h3, 2'h3},
		'{20'h00011, 18'h12345, 18'h2abcd, 2'h3, 2'h3},
		'{20'hfffff, 18'h2468a, 18'h13579, 2'h3, 2'h3},
		'{20'h00010, 18'h3ffff, 18'h3ffff, 2'h1, 2'h2},
		'{20'h00011, 18'h00000, 18'h11111, 2'h0, 2'h3},
		'{20'hfffff, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0}
	};

	logic          clock;
	logic          rst;
	logic          cmd_valid;
	logic          cmd_ready_r;
	logic          cmd_write;
	logic [AW-1:0] cmd_addr;
	logic [DW-1:0] cmd_wdata0;
	logic [DW-1:0] cmd_wdata1;
	logic [NL-1:0] cmd_lane0;
	logic [NL-1:0] cmd_lane1;
	logic          pll_off;
	logic [DW-1:0] rd_data_r;
	logic          rd_valid_r;
	logic          pll_on_mode_r;
	logic          read_busy_r;
	logic [DW-1:0] m0 [int];   // Expected contents of the first array
	logic [DW-1:0] m1 [int];   // Expected contents of the second array
	int            n_fail;
	int            checks;
	int            lat;

	bsp_link_if #(.DW(DW), .AW(AW)) lnk ();

	bsp_host_end #(.DW(DW), .AW(AW)) i_bsp_host_end (.clock(clock),
		.rst(rst), .ce(1'b1), .lnk(lnk), .cmd_valid(cmd_valid),
		.cmd_ready_r(cmd_ready_r), .cmd_write(cmd_write),
		.cmd_addr(cmd_addr), .cmd_wdata0(cmd_wdata0),
		.cmd_wdata1(cmd_wdata1), .cmd_lane0(cmd_lane0),
		.cmd_lane1(cmd_lane1), .pll_off(pll_off),
		.rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r));

	bsp_dev_end #(.DW(DW), .AW(AW)) i_bsp_dev_end (.clock(clock),
		.rst(rst), .ce(1'b1), .lnk(lnk), .pll_on_mode_r(pll_on_mode_r),
		.read_busy_r(read_busy_r));

	bsp_link_properties #(.AW(AW)) i_bsp_link_properties (.clock(clock),
		.rst(rst), .k(lnk.k), .k_n(lnk.k_n),
		.cycle_load_strobe_n(lnk.cycle_load_strobe_n),
		.access_dir_read(lnk.access_dir_read), .addr(lnk.addr),
		.pll_disable_n(lnk.pll_disable_n), .dq_host_oe(lnk.dq_host_oe),
		.dq_dev_oe(lnk.dq_dev_oe), .echo_clock_out(lnk.echo_clock_out),
		.echo_clock_out_n(lnk.echo_clock_out_n),
		.output_valid_flag(lnk.output_valid_flag));

	// 100 MHz system clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Let n edges pass, then step just past the last one
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Hold one command until the host end takes it, bounded
	task automatic send(input logic wr, input bsp_row_s r);
		int n;
		cmd_write = wr;
		cmd_addr = r.a;
		cmd_wdata0 = r.d0;
		cmd_wdata1 = r.d1;
		cmd_lane0 = r.l0;
		cmd_lane1 = r.l1;
		cmd_valid = 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (cmd_ready_r !== 1'b1 && n < 16);
		`CHK("ready", 1'b1, cmd_ready_r)
		// Valid stays up; the caller lowers it or sends the next command
		#1;
	endtask

	// Count cycles to the next returned word, bounded
	task automatic wait_word(output int n);
		n = 0;
		do
		begin
			idle(1);
			n++;
		end
		while (rd_valid_r !== 1'b1 && n < 40);
		`CHK("word_valid", 1'b1, rd_valid_r)
	endtask

	// Write one row and fold the enabled lanes into the model
	task automatic wr_row(input bsp_row_s r);
		send(1'b1, r);
		for (int i = 0; i < NL; i++)
		begin
			if (r.l0[i])
				m0[r.a][i*LW +: LW] = r.d0[i*LW +: LW];
			if (r.l1[i])
				m1[r.a][i*LW +: LW] = r.d1[i*LW +: LW];
		end
	endtask

	// Read one address, compare both words, report word0 latency
	task automatic rd_chk(input logic [AW-1:0] a, output int lt);
		bsp_row_s r;
		int n;
		r = '0;
		r.a = a;
		send(1'b0, r);
		cmd_valid = 1'b0;
		idle(4);
		`CHK("busy", 1'b1, read_busy_r)
		wait_word(lt);
		lt = lt + 4;
		`CHK("word0", m0[a], rd_data_r)
		wait_word(n);
		`CHK("word1", m1[a], rd_data_r)
	endtask

	// Verdict and end of run
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog: the tests need well under 1000 cycles
	initial
	begin
		repeat (4000) @(posedge clock);
		n_fail++;
		close_out();
	end

	initial
	begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		send_init();
		n_fail = 0;
		checks = 0;
		idle(6);
		rst = 1'b0;
		// Table: back to back writes, then read every address
		foreach (rows[i])
			wr_row(rows[i]);
		cmd_valid = 1'b0;
		idle(10);
		foreach (rows[i])
		begin
			rd_chk(rows[i].a, lat);
			`CHK("lat_on", 1'b1, lat inside {[10:14]})
		end
		$display("table rows done");
		// Loop switched off: short latency
		pll_off = 1'b1;
		idle(6);
		`CHK("pll_pin", 1'b0, lnk.pll_disable_n)
		`CHK("pll_mode", 1'b0, pll_on_mode_r)
		rd_chk(rows[1].a, lat);
		`CHK("lat_off", 1'b1, lat inside {[4:8]})
		pll_off = 1'b0;
		idle(6);
		$display("loop off done");
		// Reset in mid-run: pins idle, stored words survive
		rst = 1'b1;
		idle(2);
		`CHK("strobe", 1'b1, lnk.cycle_load_strobe_n)
		`CHK("selects", {NL{1'b1}}, lnk.byte_lane_write_select_n)
		`CHK("valid", 1'b0, lnk.output_valid_flag)
		`CHK("dev_oe", 1'b0, lnk.dq_dev_oe)
		rst = 1'b0;
		rd_chk(rows[0].a, lat);
		$display("reset done");
		close_out();
	end

	// Idle command inputs at time zero
	task automatic send_init;
		cmd_write = 1'b0;
		cmd_addr = '0;
		cmd_wdata0 = '0;
		cmd_wdata1 = '0;
		cmd_lane0 = '0;
		cmd_lane1 = '0;
		pll_off = 1'b0;
	endtask
endmodule
